// ### pkg/shc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface shc_link_if;
    logic       req;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ack;
    modport dev  (input req, wr, addr, wdata, output rdata, ack);
    modport host (output req, wr, addr, wdata, input rdata, ack);
endinterface : shc_link_if
`default_nettype wire

// ### pkg/shc_pkg.sv
`default_nettype none
package shc_pkg;
    // ========================================
    // device register map
    localparam logic [7:0] ADDR_RUN    = 8'h19;
    localparam logic [7:0] ADDR_DGL_I  = 8'h3C;
    localparam logic [7:0] ADDR_UNDERVOLT_FILTER_ENABLE = 8'h3D;
    localparam logic [7:0] ADDR_OVERVOLT_FILTER_ENABLE = 8'h3E;
    localparam logic [7:0] ADDR_RES    = 8'h3F;
    localparam logic [7:0] ADDR_DLY    = 8'h40;
    localparam logic [7:0] ADDR_PORT_V = 8'h46;
    localparam logic [7:0] ADDR_PORT_I = 8'h47;
    // ========================================
    // reset values and fields
    localparam logic [3:0] RST_RUN     = 4'hF;
    localparam logic [5:0] RST_DLY     = 6'h19;
    localparam logic [5:0] DLY_MAX     = 6'h32;
    localparam int         HIST_DEPTH  = 50;
    localparam int         SAMPLE_W    = 10;
    localparam int         BIT_V       = 0;
    localparam int         BIT_I       = 1;
    // comparator order: oc warn, uv warn, uv crit, ov warn, ov crit
    localparam int         CMP_N       = 5;
    localparam int         CMP_OC      = 0;
    localparam int         CMP_UV1     = 1;
    localparam int         CMP_UV2     = 2;
    localparam int         CMP_OV1     = 3;
    localparam int         CMP_OV2     = 4;
    localparam logic [4:0] SHUT_MASK_P0 = 5'h14;
    localparam logic [4:0] SHUT_MASK_P1 = 5'h15;
    // ========================================
    // host controller registers (apb)
    localparam logic [7:0] HOST_CMD    = 8'h00;
    localparam logic [7:0] HOST_STAT   = 8'h04;
    localparam logic [7:0] HOST_ISR    = 8'h08;
    localparam logic [7:0] HOST_IMR    = 8'h0C;
    localparam int         CMD_WR_BIT  = 16;
    localparam int         IRQ_DONE    = 0;
    localparam int         IRQ_REFUSED = 1;
    localparam int         IRQ_N       = 2;
endpackage : shc_pkg
`default_nettype wire

// ### rtl/shc_device_end.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R1: with filtering enabled, act only after two consecutive positive compares
// R2: filter enable bits at 0x3C, 0x3D, 0x3E
// R3: two 50-deep 10-bit sample histories
// R4: fault shutdown stops recording
// R5: reading history port stops that history
// R6: channel switched off stops recording
// R7: run register bit0 voltage, bit1 current
// R8: voltage port 0x46, current port 0x47
// R9: 10-bit readout: high byte then low bits
// R10: 8-bit readout: one high byte per sample
// R11: width select bit0 voltage, bit1 current
// R12: keep recording stop-delay samples after shutdown
// R13: stop delay resets to 25, range 0-50
// R14: fault shutdown latches channel off
// R15: restart only on reset or a channel pin or enable toggle
// R16: overwrite oldest, read oldest first, auto-advance
// R17: width bit 1 is high byte only
module shc_device_end (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // register link
    shc_link_if.dev                     link,
    // conversions, one strobe per sample cycle
    input  wire logic                   sampleValid,
    input  wire logic [9:0]             voltSample,
    input  wire logic [9:0]             currSample,
    input  wire logic [4:0]             rawCompare,
    // channel control
    input  wire logic                   protectionModeInput,
    input  wire logic                   channelOnPin,
    input  wire logic                   firstEnableBit,
    input  wire logic                   secondEnableBit,
    // status
    output logic                        channelOn,
    output logic                        latchedOff,
    output logic [4:0]                  compareEvent,
    output logic                        voltRecording,
    output logic                        currRecording
);
    // ========================================
    // registers
    logic [3:0] runCtl_r;
    logic [0:0] dglI_r;
    logic [1:0] dglUv_r;
    logic [1:0] dglOv_r;
    logic [1:0] resSel_r;
    logic [5:0] stopDly_r;
    logic       ack_r;
    logic [7:0] rdata_r;
    logic       take;
    logic       rdTake;
    logic       wrTake;

    assign take      = link.req && !ack_r;
    assign rdTake    = take && !link.wr;
    assign wrTake    = take && link.wr;
    assign link.ack  = ack_r;
    assign link.rdata = rdata_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            runCtl_r  <= shc_pkg::RST_RUN;          // R7
            dglI_r    <= '0;                        // R2
            dglUv_r   <= '0;
            dglOv_r   <= '0;
            resSel_r  <= '0;                        // R17
            stopDly_r <= shc_pkg::RST_DLY;          // R13
        end else if (wrTake) begin
            case (link.addr)
                shc_pkg::ADDR_RUN:    runCtl_r  <= link.wdata[3:0];
                shc_pkg::ADDR_DGL_I:  dglI_r    <= link.wdata[0:0];
                shc_pkg::ADDR_UNDERVOLT_FILTER_ENABLE: dglUv_r   <= link.wdata[1:0];
                shc_pkg::ADDR_OVERVOLT_FILTER_ENABLE: dglOv_r   <= link.wdata[1:0];
                shc_pkg::ADDR_RES:    resSel_r  <= link.wdata[1:0];
                shc_pkg::ADDR_DLY:    stopDly_r <= link.wdata[5:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) ack_r <= 1'b0;
        else       ack_r <= take;
    end

    // ========================================
    // pin sync and enable toggle detection
    logic onMeta_r;
    logic onSync_r;
    logic onDly_r;
    logic en1Dly_r;
    logic en2Dly_r;
    logic toggle;
    logic pinsOn;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            onMeta_r <= 1'b0;
            onSync_r <= 1'b0;
            onDly_r  <= 1'b0;
            en1Dly_r <= 1'b0;
            en2Dly_r <= 1'b0;
        end else begin
            onMeta_r <= channelOnPin;
            onSync_r <= onMeta_r;
            onDly_r  <= onSync_r;
            en1Dly_r <= firstEnableBit;
            en2Dly_r <= secondEnableBit;
        end
    end

    assign toggle = (onSync_r ^ onDly_r) | (firstEnableBit ^ en1Dly_r)
                  | (secondEnableBit ^ en2Dly_r);
    assign pinsOn = onSync_r && firstEnableBit && secondEnableBit;

    // ========================================
    // comparator filtering
    logic [4:0] prevCmp_r;
    logic [4:0] dglEn;
    logic [4:0] passed;
    logic [4:0] shutMask;
    logic       shutCause;

    assign dglEn = {dglOv_r[1], dglOv_r[0], dglUv_r[1], dglUv_r[0], dglI_r[0]};  // R2
    assign passed = rawCompare & (prevCmp_r | ~dglEn);                          // R1
    assign shutMask = protectionModeInput ? shc_pkg::SHUT_MASK_P1 : shc_pkg::SHUT_MASK_P0;
    assign shutCause = sampleValid && |(passed & shutMask);                     // R1

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prevCmp_r    <= '0;
            compareEvent <= '0;
        end else begin
            compareEvent <= sampleValid ? passed : '0;
            if (sampleValid) prevCmp_r <= rawCompare;
        end
    end

    // ========================================
    // latched-off fault handling
    // set wins over a toggle in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn)                      latchedOff <= 1'b0;
        else if (pinsOn && shutCause)   latchedOff <= 1'b1;   // R14
        else if (toggle)                latchedOff <= 1'b0;   // R15
    end

    assign channelOn = pinsOn && !latchedOff;

    // ========================================
    // post-shutdown stop delay
    logic       pfActive_r;
    logic       pfDone_r;
    logic [5:0] pfCnt_r;
    logic       faultEdge;
    logic       pfLast;

    assign faultEdge = pinsOn && shutCause && !latchedOff;
    assign pfLast    = pfActive_r && (pfCnt_r == '0);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pfActive_r <= 1'b0;
            pfDone_r   <= 1'b0;
            pfCnt_r    <= '0;
        end else if (faultEdge) begin
            pfActive_r <= 1'b1;
            // values above the top of range act as the top
            pfCnt_r    <= (stopDly_r > shc_pkg::DLY_MAX) ? shc_pkg::DLY_MAX : stopDly_r;  // R13
        end else if (toggle) begin
            pfActive_r <= 1'b0;
            pfDone_r   <= 1'b0;
        end else if (sampleValid && pfActive_r) begin
            if (pfLast) begin
                pfActive_r <= 1'b0;
                pfDone_r   <= 1'b1;                          // R12
            end else begin
                pfCnt_r <= pfCnt_r - 6'h01;                  // R12
            end
        end
    end

    // ========================================
    // recording gates
    logic [1:0] readFreeze_r;
    logic       recCommon;
    logic       wrV;
    logic       wrI;

    // pins switched off stops, a fault shutdown stops after the delay
    assign recCommon = (pinsOn || pfActive_r) && !pfDone_r && !pfLast;  // R4 R6
    assign voltRecording = runCtl_r[shc_pkg::BIT_V] && !readFreeze_r[shc_pkg::BIT_V] && recCommon;  // R7 R5
    assign currRecording = runCtl_r[shc_pkg::BIT_I] && !readFreeze_r[shc_pkg::BIT_I] && recCommon;
    assign wrV = sampleValid && voltRecording;
    assign wrI = sampleValid && currRecording;

    // ========================================
    // block readout
    logic [1:0] blkSel_r;
    logic       half_r;
    logic       isV;
    logic       isI;
    logic       isPort;
    logic       start;
    logic       phase;
    logic       hiOnly;
    logic [9:0] vData;
    logic [9:0] iData;
    logic [9:0] smp;

    assign isV    = link.addr == shc_pkg::ADDR_PORT_V;  // R8
    assign isI    = link.addr == shc_pkg::ADDR_PORT_I;  // R8
    assign isPort = isV || isI;
    assign start  = isV ? !blkSel_r[shc_pkg::BIT_V] : !blkSel_r[shc_pkg::BIT_I];
    assign phase  = !start && half_r;
    assign hiOnly = isV ? resSel_r[shc_pkg::BIT_V] : resSel_r[shc_pkg::BIT_I];  // R11 R17
    assign smp    = isV ? vData : iData;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            blkSel_r <= '0;
            half_r   <= 1'b0;
        end else if (take) begin
            blkSel_r <= (rdTake && isPort) ? {isI, isV} : 2'b00;
            half_r   <= rdTake && isPort && !hiOnly && !phase;   // R9
        end
    end

    // a run bit written to one thaws a history frozen by readout
    always_ff @(posedge clk) begin
        if (!rstn) begin
            readFreeze_r <= '0;
        end else begin
            if (rdTake && isV) readFreeze_r[shc_pkg::BIT_V] <= 1'b1;   // R5
            else if (wrTake && link.addr == shc_pkg::ADDR_RUN && link.wdata[shc_pkg::BIT_V])
                readFreeze_r[shc_pkg::BIT_V] <= 1'b0;
            if (rdTake && isI) readFreeze_r[shc_pkg::BIT_I] <= 1'b1;   // R5
            else if (wrTake && link.addr == shc_pkg::ADDR_RUN && link.wdata[shc_pkg::BIT_I])
                readFreeze_r[shc_pkg::BIT_I] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else if (rdTake) begin
            case (link.addr)
                shc_pkg::ADDR_RUN:    rdata_r <= {4'h0, runCtl_r};
                shc_pkg::ADDR_DGL_I:  rdata_r <= {7'h00, dglI_r};
                shc_pkg::ADDR_UNDERVOLT_FILTER_ENABLE: rdata_r <= {6'h00, dglUv_r};
                shc_pkg::ADDR_OVERVOLT_FILTER_ENABLE: rdata_r <= {6'h00, dglOv_r};
                shc_pkg::ADDR_RES:    rdata_r <= {6'h00, resSel_r};
                shc_pkg::ADDR_DLY:    rdata_r <= {2'h0, stopDly_r};
                shc_pkg::ADDR_PORT_V,
                shc_pkg::ADDR_PORT_I: rdata_r <= phase ? {6'h00, smp[1:0]} : smp[9:2];  // R9 R10
                default:              rdata_r <= 8'h00;
            endcase
        end
    end

    // ========================================
    // histories
    logic advance;

    assign advance = hiOnly || phase;  // R10 R16

    shc_history #(.DEPTH(shc_pkg::HIST_DEPTH), .WIDTH(shc_pkg::SAMPLE_W)) u_histV (  // R3
        .clk       (clk),
        .rstn      (rstn),
        .wrEn      (wrV),
        .wrData    (voltSample),
        .rdStart   (rdTake && isV && start),
        .rdAdvance (rdTake && isV && advance),
        .rdData    (vData)
    );

    shc_history #(.DEPTH(shc_pkg::HIST_DEPTH), .WIDTH(shc_pkg::SAMPLE_W)) u_histI (  // R3
        .clk       (clk),
        .rstn      (rstn),
        .wrEn      (wrI),
        .wrData    (currSample),
        .rdStart   (rdTake && isI && start),
        .rdAdvance (rdTake && isI && advance),
        .rdData    (iData)
    );
endmodule : shc_device_end
`default_nettype wire

// ### rtl/shc_history.sv
`timescale 1ns/10ps
`default_nettype none
module shc_history #(
    parameter int DEPTH = shc_pkg::HIST_DEPTH,
    parameter int WIDTH = shc_pkg::SAMPLE_W
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // recording side
    input  wire logic             wrEn,
    input  wire logic [WIDTH-1:0] wrData,
    // readout side
    input  wire logic             rdStart,
    input  wire logic             rdAdvance,
    output logic      [WIDTH-1:0] rdData
);
    localparam int PW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || WIDTH < 2) begin : g_chk
            $error("shc_history: DEPTH and WIDTH must be at least 2");
        end
    endgenerate

    function automatic logic [PW-1:0] wrapInc(input logic [PW-1:0] p);
        wrapInc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : wrapInc

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_r;
    logic [PW-1:0]    rdPtr_r;
    logic             full_r;
    logic [PW-1:0]    base;

    // ========================================
    // recording: oldest entry is overwritten
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wrPtr_r <= '0;
            full_r  <= 1'b0;
        end else if (wrEn) begin
            wrPtr_r <= wrapInc(wrPtr_r);
            if (wrPtr_r == PW'(DEPTH - 1)) full_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (wrEn) mem[wrPtr_r] <= wrData;
    end

    // ========================================
    // readout: oldest to newest
    always_comb begin
        base   = rdStart ? (full_r ? wrPtr_r : '0) : rdPtr_r;
        rdData = mem[base];
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdPtr_r <= '0;
        end else if (rdStart || rdAdvance) begin
            rdPtr_r <= rdAdvance ? wrapInc(base) : base;
        end
    end
endmodule : shc_history
`default_nettype wire

// ### rtl/shc_host_end.sv
`timescale 1ns/10ps
`default_nettype none
module shc_host_end (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt
    output logic             irq,
    // register link
    shc_link_if.host         link
);
    typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_GAP} shc_host_e;

    shc_host_e                 state_r;
    logic [7:0]                addr_r;
    logic [7:0]                wdata_r;
    logic                      wr_r;
    logic [7:0]                rdByte_r;
    logic [shc_pkg::IRQ_N-1:0] isr_r;
    logic [shc_pkg::IRQ_N-1:0] imr_r;
    logic                      apbWr;
    logic                      apbRd;
    logic                      cmdWr;
    logic                      busy;
    logic                      done;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign apbWr   = psel && penable && pwrite;
    assign apbRd   = psel && penable && !pwrite;
    assign busy    = state_r != ST_IDLE;
    assign cmdWr   = apbWr && paddr == shc_pkg::HOST_CMD;
    assign done    = state_r == ST_REQ && link.ack;

    assign link.req   = state_r == ST_REQ;
    assign link.wr    = wr_r;
    assign link.addr  = addr_r;
    assign link.wdata = wdata_r;

    // ========================================
    // link sequencer; the gap cycle lets the device see req fall
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r  <= ST_IDLE;
            addr_r   <= '0;
            wdata_r  <= '0;
            wr_r     <= 1'b0;
            rdByte_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cmdWr) begin
                        addr_r  <= pwdata[7:0];
                        wdata_r <= pwdata[15:8];
                        wr_r    <= pwdata[shc_pkg::CMD_WR_BIT];
                        state_r <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (link.ack) begin
                        if (!wr_r) rdByte_r <= link.rdata;
                        state_r <= ST_GAP;
                    end
                end
                ST_GAP:  state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ========================================
    // interrupt status: read clears, a new event wins
    logic [shc_pkg::IRQ_N-1:0] evt;

    assign evt = {cmdWr && busy, done};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            isr_r <= '0;
        end else begin
            isr_r <= ((apbRd && paddr == shc_pkg::HOST_ISR) ? '0 : isr_r) | evt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn)                                imr_r <= '0;
        else if (apbWr && paddr == shc_pkg::HOST_IMR) imr_r <= pwdata[shc_pkg::IRQ_N-1:0];
    end

    assign irq = |(isr_r & imr_r);

    always_comb begin
        case (paddr)
            shc_pkg::HOST_CMD:  prdata = {15'h0000, wr_r, wdata_r, addr_r};
            shc_pkg::HOST_STAT: prdata = {16'h0000, rdByte_r, 7'h00, busy};
            shc_pkg::HOST_ISR:  prdata = {30'h00000000, isr_r};
            shc_pkg::HOST_IMR:  prdata = {30'h00000000, imr_r};
            default:            prdata = 32'h00000000;
        endcase
    end
endmodule : shc_host_end
`default_nettype wire

// ### verif/sample_history_capture_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module sample_history_capture_tb_top;
    logic clk = 1'b0;
    logic rstn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata, q;
    logic sampleValid, protectionModeInput, channelOnPin, firstEnableBit, secondEnableBit;
    logic [9:0] voltSample, currSample, s;
    logic [4:0] rawCompare, compareEvent, ev;
    logic channelOn, latchedOff, voltRecording, currRecording;
    int bad_count = 0;
    int cmp_count = 0;
    always #5 clk = ~clk;
    shc_link_if link ();
    shc_host_end shc_host_end_inst (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
    shc_device_end shc_device_end_inst (.clk(clk), .rstn(rstn), .link(link), .sampleValid(sampleValid),
        .voltSample(voltSample), .currSample(currSample), .rawCompare(rawCompare),
        .protectionModeInput(protectionModeInput), .channelOnPin(channelOnPin), .firstEnableBit(firstEnableBit),
        .secondEnableBit(secondEnableBit), .channelOn(channelOn), .latchedOff(latchedOff),
        .compareEvent(compareEvent), .voltRecording(voltRecording), .currRecording(currRecording));
    shc_link_assertions shc_link_assertions_inst (.clk(clk), .rstn(rstn), .req(link.req), .wr(link.wr),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
    // ========================================
    // tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        chk(pslverr, 32'h0);
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // device access through the host end; polls busy, bounded
    task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        logic [31:0] t;
        apb(1'b1, shc_pkg::HOST_CMD, {15'h0000, w, d, a}, t);
        repeat (50) begin
            apb(1'b0, shc_pkg::HOST_STAT, 32'h0, t);
            if (t[0] === 1'b0) break;
        end
        // a poll limit that runs out counts as a mismatch
        chk(t[0], 32'h0);
        r = t[15:8];
    endtask : dev
    task automatic feed(input int v, input int c, input logic [4:0] raw);
        @(posedge clk);
        sampleValid <= 1'b1; voltSample <= 10'(v); currSample <= 10'(c); rawCompare <= raw;
        @(posedge clk);
        sampleValid <= 1'b0;
        @(posedge clk);
        // filtered result stands for the one cycle after the sample
        ev = compareEvent;
        repeat (2) @(posedge clk);
        #1;
    endtask : feed
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        finish_test();
    end
    // ========================================
    // scenarios
    initial begin : main
        logic [7:0] ra[6] = '{8'h19, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h40};
        logic [7:0] re[6] = '{8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h19};
        logic [7:0] wv[6] = '{8'h0F, 8'h01, 8'h03, 8'h03, 8'h00, 8'h32};
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        sampleValid = 1'b0; voltSample = 10'h000; currSample = 10'h000; rawCompare = 5'h00;
        protectionModeInput = 1'b0; channelOnPin = 1'b1; firstEnableBit = 1'b1; secondEnableBit = 1'b1;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            dev(1'b0, ra[i], 8'h00, b);
            chk(b, re[i]);
            dev(1'b1, ra[i], wv[i], b);
            dev(1'b0, ra[i], 8'h00, b);
            chk(b, wv[i]);
        end
        dev(1'b0, 8'h50, 8'h00, b);
        chk(b, 8'h00);
        // interrupt: done raises irq, a command while busy is refused
        apb(1'b0, shc_pkg::HOST_ISR, 32'h0, q);
        apb(1'b1, shc_pkg::HOST_IMR, 32'h1, q);
        dev(1'b0, 8'h3C, 8'h00, b);
        #1;
        chk(irq, 1'b1);
        repeat (2) apb(1'b1, shc_pkg::HOST_CMD, 32'h0, q);
        repeat (10) @(posedge clk);
        apb(1'b0, shc_pkg::HOST_ISR, 32'h0, q);
        chk(q[1:0], 2'h3);
        #1;
        chk(irq, 1'b0);
        // 60 samples into 50 entries: oldest ten are overwritten
        for (int k = 0; k < 60; k++) feed(k * 7 + 1, k * 11 + 3, 5'h00);
        for (int i = 0; i < 50; i++) begin
            s = 10'((i + 10) * 7 + 1);
            dev(1'b0, shc_pkg::ADDR_PORT_V, 8'h00, b);
            chk(b, s[9:2]);
            dev(1'b0, shc_pkg::ADDR_PORT_V, 8'h00, b);
            chk(b, {6'h00, s[1:0]});
        end
        #1;
        chk(voltRecording, 1'b0);
        chk(currRecording, 1'b1);
        dev(1'b1, shc_pkg::ADDR_RES, 8'h02, b);
        for (int i = 0; i < 50; i++) begin
            s = 10'((i + 10) * 11 + 3);
            dev(1'b0, shc_pkg::ADDR_PORT_I, 8'h00, b);
            chk(b, s[9:2]);
        end
        dev(1'b1, shc_pkg::ADDR_RUN, 8'h03, b);
        #1;
        chk({voltRecording, currRecording}, 2'h3);
        dev(1'b1, shc_pkg::ADDR_RUN, 8'h01, b);
        #1;
        chk({voltRecording, currRecording}, 2'h2);
        // switching off stops recording at once; the stop delay only follows a fault shutdown
        dev(1'b1, shc_pkg::ADDR_RUN, 8'h03, b);
        dev(1'b1, shc_pkg::ADDR_DLY, 8'h00, b);
        @(posedge clk) secondEnableBit <= 1'b0;
        feed(1, 1, 5'h00);
        chk({channelOn, voltRecording}, 2'h0);
        @(posedge clk) secondEnableBit <= 1'b1;
        feed(2, 2, 5'h00);
        chk({channelOn, voltRecording}, 2'h3);
        // deglitched undervoltage: an isolated hit is ignored, two in a row latch off
        dev(1'b1, shc_pkg::ADDR_DLY, 8'h02, b);
        feed(3, 3, 5'h04);
        chk(ev, 5'h00);
        feed(4, 4, 5'h00);
        chk(latchedOff, 1'b0);
        feed(5, 5, 5'h04);
        chk(latchedOff, 1'b0);
        feed(6, 6, 5'h04);
        chk(ev, 5'h04);
        chk({latchedOff, channelOn}, 2'h2);
        for (int i = 0; i < 4; i++) begin
            chk(voltRecording, 1'(i < 2));
            feed(7 + i, 7 + i, 5'h00);
        end
        chk(latchedOff, 1'b1);
        @(posedge clk) firstEnableBit <= 1'b0;
        @(posedge clk) firstEnableBit <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({latchedOff, channelOn}, 2'h1);
        // unfiltered oc warning: shuts down only in protection mode; pin toggle restarts
        dev(1'b1, shc_pkg::ADDR_DGL_I, 8'h00, b);
        feed(20, 20, 5'h01);
        chk({ev, latchedOff}, {5'h01, 1'b0});
        @(posedge clk) protectionModeInput <= 1'b1;
        feed(21, 21, 5'h01);
        chk({ev, latchedOff, channelOn}, {5'h01, 2'h2});
        @(posedge clk) channelOnPin <= 1'b0;
        repeat (4) @(posedge clk);
        channelOnPin <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({latchedOff, channelOn}, 2'h1);
        finish_test();
    end
endmodule : sample_history_capture_tb_top
`default_nettype wire

// ### verif/shc_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module shc_link_assertions (
    // clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // register link
    input wire logic       req,
    input wire logic       wr,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ========================================
    // handshake steps
    sequence taken_s;
        req && !ack;
    endsequence
    sequence answer_s;
        ack ##1 (!req && !ack);
    endsequence
    // ========================================
    // link rules
    answer_order_a: assert property (taken_s |=> answer_s)
        else $error("link request not answered then released");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("link ack longer than one cycle");
    ack_cause_a: assert property (ack |-> $past(req) && !$past(ack))
        else $error("link ack without a request taken one cycle before");
    no_spurious_a: assert property (!req |=> !ack)
        else $error("link ack while no request");
    request_hold_a: assert property (taken_s |=> $stable(addr) && $stable(wr) && $stable(wdata))
        else $error("link request changed before ack");
    read_hold_a: assert property (!(req && !ack && !wr) |=> $stable(rdata))
        else $error("link read data changed without a read");
    unmapped_zero_a: assert property (req && !ack && !wr && addr > 8'h47 |=> rdata == 8'h00)
        else $error("unmapped link read not zero");
    reset_quiet_a: assert property (disable iff (1'b0) !rstn |=> !ack && !req)
        else $error("link active after reset");
endmodule : shc_link_assertions
`default_nettype wire
